// ==== hdl/sdam_regs.vh ====
`ifndef SDAM_REGS_VH
`define SDAM_REGS_VH
// command codes {cs_n, ras_n, cas_n, we_n}
`define SDAM_CMD_ACTIVE      4'h3
`define SDAM_CMD_READ        4'h5
`define SDAM_CMD_WRITE       4'h4
`define SDAM_CMD_PRECHARGE   4'h2
`define SDAM_CMD_LOAD_MODE   4'h0
// field positions
`define SDAM_SCOPE_BIT       10
`define SDAM_LANE_BITS       8
// read mask to high-z latency, clocks
`define SDAM_RD_MASK_LAT     2
// reset values
`define SDAM_MODE_RST        14'h0000
`define SDAM_ROW_RST         14'h0000
`define SDAM_COL_RST         14'h0000
`define SDAM_BANK_RST        2'h0
`define SDAM_AUTO_PRE_RST    1'h0
`endif

// ==== hdl/sdam_lane.v ====
`timescale 1ns/10ps
// one byte lane: write masking and delayed read output disable
module sdam_lane #(
    parameter LAT = 2
) (
    input  wire       ref_clk,
    input  wire       sys_rst,
    input  wire       mask,
    input  wire       wr_slot,
    input  wire       rd_slot,
    input  wire [7:0] wr_byte,
    input  wire [7:0] old_byte,
    output reg  [7:0] new_byte,
    output wire       out_en
);
    reg [LAT-1:0] rd_hiz_q;

    // masked write keeps the stored byte
    always @* begin
        if (wr_slot && mask)
            new_byte = old_byte;
        else
            new_byte = wr_byte;
    end

    // mask sampled now reaches the drivers LAT clocks later; LAT >= 2
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            rd_hiz_q <= {LAT{1'h1}};
        else
            rd_hiz_q <= {rd_hiz_q[LAT-2:0], mask};
    end

    assign out_en = rd_slot & ~rd_hiz_q[LAT-1];
endmodule

// ==== hdl/sdam_decode.v ====
// Operation
// - a byte mask high during a write leaves that stored byte unchanged.
// - a byte mask high during a read floats that lane two clocks later.
// - in the 16-bit organisation low mask is bits 7..0, high is 15..8.
// - in the 32-bit organisation mask bit n governs data byte n.
// - bank select names the bank for active, read, write and precharge.
// - bank select is ignored when precharge has the scope bit high.
// - active takes the row, read or write the column and auto precharge.
// - precharge closes all banks with scope high, else the selected bank.
// - load mode register takes its op-code from the address inputs.
// - every input is sampled on the rising clock edge; the write mask, the write command pins, wr_data, old_data, rd_slot and sys_rst act without a clock edge.
// - with chip select high the command is ignored.
`timescale 1ns/10ps
`include "sdam_regs.vh"
module sdam_decode #(
    parameter DQ_W   = 32,
    parameter ADDR_W = 14
) (
    input  wire                 ref_clk,
    input  wire                 sys_rst,
    input  wire                 cs_n,
    input  wire                 ras_n,
    input  wire                 cas_n,
    input  wire                 we_n,
    input  wire                 bank_select_bit0,
    input  wire                 bank_select_bit1,
    input  wire [ADDR_W-1:0]    addr,
    input  wire [DQ_W/8-1:0]    byte_mask,
    input  wire [DQ_W-1:0]      wr_data,
    input  wire [DQ_W-1:0]      old_data,
    input  wire                 rd_slot,
    output wire [DQ_W-1:0]      merged_data,
    output wire [DQ_W/8-1:0]    dq_oe,
    output reg  [ADDR_W-1:0]    mode_q,
    output reg  [ADDR_W-1:0]    row_q,
    output reg  [ADDR_W-1:0]    col_q,
    output reg  [1:0]           bank_q,
    output reg                  auto_pre_q,
    output reg                  act_q,
    output reg                  rd_q,
    output reg                  wr_q,
    output reg  [3:0]           close_q
);
    localparam NL = DQ_W / `SDAM_LANE_BITS;
    localparam NB = 4;
    // x16 parts build with DQ_W = 16: two lanes, low then high

    // command word, chip select in the top bit
    wire [3:0]        cmd;
    wire [1:0]        bank;
    wire              scope;
    wire              is_wr;
    wire              is_pre;
    wire              wr_slot;
    wire [NB-1:0]     bank_hot;
    wire [NB-1:0]     close_d;

    // next values
    reg  [ADDR_W-1:0] mode_d;
    reg  [ADDR_W-1:0] row_d;
    reg  [ADDR_W-1:0] col_d;
    reg  [1:0]        bank_d;
    reg               auto_pre_d;
    reg               act_d;
    reg               rd_d;
    reg               wr_d;

    assign cmd   = {cs_n, ras_n, cas_n, we_n};
    assign bank  = {bank_select_bit1, bank_select_bit0};
    assign scope = addr[`SDAM_SCOPE_BIT];

    // codes carry cs_n, so a deselected cycle never matches
    assign is_wr  = (cmd == `SDAM_CMD_WRITE);
    assign is_pre = (cmd == `SDAM_CMD_PRECHARGE);

    // write slot is the write command cycle and the cycle after it (wr_q)
    assign wr_slot = is_wr | wr_q;

    // lane n: bit n of the mask; for x16 low=0 high=1
    genvar i;
    generate
        for (i = 0; i < NL; i = i + 1) begin : g_lane
            sdam_lane #(
                .LAT (`SDAM_RD_MASK_LAT)
            ) u_lane (
                .ref_clk  (ref_clk),
                .sys_rst  (sys_rst),
                .mask     (byte_mask[i]),
                .wr_slot  (wr_slot),
                .rd_slot  (rd_slot),
                .wr_byte  (wr_data[i*`SDAM_LANE_BITS +: `SDAM_LANE_BITS]),
                .old_byte (old_data[i*`SDAM_LANE_BITS +: `SDAM_LANE_BITS]),
                .new_byte (merged_data[i*`SDAM_LANE_BITS +: `SDAM_LANE_BITS]),
                .out_en   (dq_oe[i])
            );
        end
    endgenerate

    // bank number as one bit per bank
    assign bank_hot = {{(NB-1){1'h0}}, 1'h1} << bank;

    // scope high closes every bank whatever the bank pins say
    genvar b;
    generate
        for (b = 0; b < NB; b = b + 1) begin : g_bank
            assign close_d[b] = is_pre & (scope | bank_hot[b]);
        end
    endgenerate

    // address captures hold until their own command comes
    always @* begin
        row_d      = row_q;
        col_d      = col_q;
        bank_d     = bank_q;
        auto_pre_d = auto_pre_q;
        case (cmd)
        `SDAM_CMD_ACTIVE: begin
            row_d  = addr;
            bank_d = bank;
        end
        `SDAM_CMD_READ: begin
            col_d      = addr;
            auto_pre_d = scope;
            bank_d     = bank;
        end
        `SDAM_CMD_WRITE: begin
            col_d      = addr;
            auto_pre_d = scope;
            bank_d     = bank;
        end
        default: begin
            // precharge keeps the last access bank; close_d names the bank from the bank pins
            bank_d = bank_q;
        end
        endcase
    end

    // op-code only moves on a load mode register command
    always @* begin
        mode_d = mode_q;
        case (cmd)
        `SDAM_CMD_LOAD_MODE: begin
            mode_d = addr;
        end
        default: begin
            mode_d = mode_q;
        end
        endcase
    end

    // one-cycle strobes for the array side
    always @* begin
        act_d = 1'h0;
        rd_d  = 1'h0;
        wr_d  = 1'h0;
        case (cmd)
        `SDAM_CMD_ACTIVE: begin
            act_d = 1'h1;
        end
        `SDAM_CMD_READ: begin
            rd_d = 1'h1;
        end
        `SDAM_CMD_WRITE: begin
            wr_d = 1'h1;
        end
        default: begin
            act_d = 1'h0;
        end
        endcase
    end

    // row and bank, sampled on the rising edge
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            row_q  <= `SDAM_ROW_RST;
            bank_q <= `SDAM_BANK_RST;
        end else begin
            row_q  <= row_d;
            bank_q <= bank_d;
        end
    end

    // column and auto precharge flag
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            col_q      <= `SDAM_COL_RST;
            auto_pre_q <= `SDAM_AUTO_PRE_RST;
        end else begin
            col_q      <= col_d;
            auto_pre_q <= auto_pre_d;
        end
    end

    // mode register
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= `SDAM_MODE_RST;
        end else begin
            mode_q <= mode_d;
        end
    end

    // strobes last one cycle, so a held command repeats them
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            act_q <= 1'h0;
            rd_q  <= 1'h0;
            wr_q  <= 1'h0;
        end else begin
            act_q <= act_d;
            rd_q  <= rd_d;
            wr_q  <= wr_d;
        end
    end

    // close strobes, one bit per bank
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            close_q <= 4'h0;
        end else begin
            close_q <= close_d;
        end
    end
endmodule

// ==== test/sdam_decode_assertions.sv ====
`timescale 1ns/10ps
module sdam_chk #(
    parameter DQ_W   = 32,
    parameter ADDR_W = 14
) (
    input logic              ref_clk,
    input logic              sys_rst,
    input logic              cs_n,
    input logic              ras_n,
    input logic              cas_n,
    input logic              we_n,
    input logic              rd_slot,
    input logic              bank_select_bit0,
    input logic              bank_select_bit1,
    input logic              auto_pre_q,
    input logic              act_q,
    input logic              rd_q,
    input logic              wr_q,
    input logic [1:0]        bank_q,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] mode_q,
    input logic [ADDR_W-1:0] row_q,
    input logic [ADDR_W-1:0] col_q,
    input logic [DQ_W/8-1:0] byte_mask,
    input logic [DQ_W/8-1:0] dq_oe,
    input logic [3:0]        close_q
);
    wire [3:0] c = {cs_n, ras_n, cas_n, we_n};
    wire [1:0] bs = {bank_select_bit1, bank_select_bit0};
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_ACT: assert property (c == 4'h3 |=> act_q &&
        row_q == $past(addr) && bank_q == $past(bs)) else $error("act");
    AST_RD: assert property (c == 4'h5 |=> rd_q && col_q == $past(addr)
        && auto_pre_q == $past(addr[10])) else $error("rd");
    AST_WR: assert property (c == 4'h4 |=> wr_q && bank_q == $past(bs))
        else $error("wr");
    AST_LMR: assert property (c == 4'h0 |=> mode_q == $past(addr))
        else $error("lmr");
    AST_ALL: assert property (c == 4'h2 && addr[10]
        |=> close_q == 4'hf) else $error("all");
    AST_ONE: assert property (c == 4'h2 && !addr[10]
        |=> close_q == 4'h1 << $past(bs)) else $error("one");
    AST_CS: assert property (cs_n |=> !(act_q | rd_q | wr_q)
        && close_q == 4'h0) else $error("cs");
    // mask pipeline is forced to masked through reset, so skip two edges
    sequence s_settled;
        !$past(sys_rst) && !$past(sys_rst, 2);
    endsequence
    AST_OE: assert property (s_settled
        |-> dq_oe == ({DQ_W/8{rd_slot}} & ~$past(byte_mask, 2)))
        else $error("oe");
endmodule
bind sdam_decode sdam_chk #(.DQ_W(DQ_W), .ADDR_W(ADDR_W)) chk_u (.*);

// ==== test/sdam_ctrl_model.sv ====
`timescale 1ns/10ps
// far-side controller: moves lines on the falling edge, so they stand
// still around the rising edge where the device samples them
module sdam_ctrl (
    input  logic        ref_clk,
    output logic [3:0]  cmd,
    output logic [1:0]  bank,
    output logic [13:0] addr,
    output logic [3:0]  mask
);
    initial {cmd, bank, addr, mask} = 24'hf00000;
    task automatic send(input logic [23:0] v);
        @(negedge ref_clk);
        {cmd, bank} = v[23:18];
        addr = v[23] ? ~addr : v[17:4]; // deselected: junk, not stale
        mask = v[3:0];
    endtask
endmodule

// ==== test/sdam_address_mask_decode_bench.sv ====
`timescale 1ns/10ps
module sdam_address_mask_decode_bench;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, rd_slot = 1'b0;
    logic        act_q, rd_q, wr_q, auto_pre_q;
    logic [3:0]  cmd, mask, oe, close_q;
    logic [1:0]  bank, bank_q;
    logic [13:0] addr, row_q, col_q, mode_q;
    logic [31:0] merged;
    int          n_mismatch = 0, checked = 0;
    logic [30:0] rows [7] = '{{24'h39abc0, 7'h40}, {24'h544000, 7'h20},
        {24'h4c0120, 7'h10}, {24'h240000, 7'h02}, {24'h284000, 7'h0f},
        {24'h001230, 7'h00}, {24'hb00000, 7'h00}};
    sdam_ctrl ctrl_u (.ref_clk(ref_clk), .cmd(cmd), .bank(bank),
        .addr(addr), .mask(mask));
    sdam_decode dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cmd[3]),
        .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
        .bank_select_bit0(bank[0]), .bank_select_bit1(bank[1]), .addr(addr),
        .byte_mask(mask), .wr_data(32'h11223344), .old_data(32'haabbccdd),
        .rd_slot(rd_slot), .merged_data(merged), .dq_oe(oe),
        .mode_q(mode_q), .row_q(row_q), .col_q(col_q), .bank_q(bank_q),
        .auto_pre_q(auto_pre_q), .act_q(act_q),
        .rd_q(rd_q), .wr_q(wr_q), .close_q(close_q));
    always #10 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checked %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #4000;
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (16) @(negedge ref_clk);
        sys_rst = 1'b0;
        rd_slot = 1'b1;
        @(negedge ref_clk);
        check({row_q, 14'h0, oe}, 32'h0);
        $display("reset done");
        // a held command repeats each edge; pulses are read after the first
        for (int i = 0; i < 7; i++) begin
            ctrl_u.send(rows[i][30:7]);
            @(negedge ref_clk);
            check({25'h0, act_q, rd_q, wr_q, close_q},
                32'(rows[i][6:0]));
        end
        $display("table done");
        check({mode_q, 2'h0, row_q, 2'h0},
            {14'h0123, 2'h0, 14'h1abc, 2'h0});
        check({col_q, bank_q, 16'h0}, {14'h0012, 2'h3, 16'h0});
        ctrl_u.send(24'h504000);
        @(negedge ref_clk);
        check({col_q, 17'h0, auto_pre_q}, {14'h0400, 17'h0, 1'b1});
        ctrl_u.send({4'h4, 20'h5});
        @(negedge ref_clk);
        check(merged, 32'h11bb33dd);
        check({31'h0, auto_pre_q}, 32'h0);
        ctrl_u.send({4'h5, 20'h6});
        ctrl_u.send({4'hf, 20'h0});
        @(negedge ref_clk);
        check({28'h0, oe}, 32'h9);
        @(negedge ref_clk);
        check({28'h0, oe}, 32'hf);
        rd_slot = 1'b0;
        @(negedge ref_clk);
        check({28'h0, oe}, 32'h0);
        $display("mask tests done");
        // reset again in mid-run: captures clear, lanes masked two edges
        sys_rst = 1'b1;
        rd_slot = 1'b1;
        @(negedge ref_clk);
        check({mode_q, col_q, oe}, 32'h0);
        check({row_q, bank_q, auto_pre_q, 15'h0}, 32'h0);
        sys_rst = 1'b0;
        @(negedge ref_clk);
        check({28'h0, oe}, 32'h0);
        @(negedge ref_clk);
        check({28'h0, oe}, 32'hf);
        $display("reset test done");
        final_report();
    end
endmodule
